//--- logic/spoc_pkg.sv
// Shared constants for the switch protection and off-time controller
package spoc_pkg;
  // Timebase
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Leading-edge blanking, least time, rounded up
  localparam int unsigned BLANK_NS      = 250;
  localparam int unsigned BLANK_CYC     =
    (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Maximum on-time, longest time, rounded down
  localparam int unsigned ON_MAX_NS     = 4000;
  localparam int unsigned ON_MAX_CYC    = (ON_MAX_NS * 1000) / CLK_PERIOD_PS;
  // On-interval timeout for runaway protection
  localparam int unsigned ON_TO_NS      = 1000;
  localparam int unsigned ON_TO_CYC     = (ON_TO_NS * 1000) / CLK_PERIOD_PS;
  // Minimum off-time and one off-time step
  localparam int unsigned OFF_MIN_NS    = 8000;
  localparam int unsigned OFF_MIN_CYC   =
    (OFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OFF_STEP_NS   = 7000;
  localparam int unsigned OFF_STEP_CYC  = (OFF_STEP_NS * 1000) / CLK_PERIOD_PS;
  // Number of off-time steps above the minimum
  localparam int unsigned OFF_STEPS     = 15;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h8;
  localparam logic [3:0] REG_STATE  = 4'hc;

  // Control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic        CTRL_RST    = 1'b0;

  // Event bits, shared by status and mask
  localparam int unsigned EV_W        = 4;
  localparam int unsigned EV_CLIM     = 0;
  localparam int unsigned EV_UP       = 1;
  localparam int unsigned EV_THERM    = 2;
  localparam int unsigned EV_OVL      = 3;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // State register fields
  localparam int unsigned ST_GATE_BIT = 0;
  localparam int unsigned ST_OT_BIT   = 1;
  localparam int unsigned ST_CL_BIT   = 2;
  localparam int unsigned ST_IDX_LSB  = 8;

  typedef enum logic [1:0] {
    SPOC_IDLE,
    SPOC_ON,
    SPOC_OFF
  } spoc_state_t;
endpackage

//--- logic/spoc_ctrl.sv
// Protection and adaptive off-time controller with a Wishbone register port
// Functional notes
// - Current above limit sets the flag, drops gate reset and the gate.
// - Current-limit flag clears only after the switching pulse falls.
// - Flag is held off for a blanking interval after gate rises.
// - On-time shorter than timeout lengthens next off-time one step.
// - On-time longer than timeout shortens next off-time one step.
// - Off-time steps every cycle while on-time stays on one side.
// - Off-time saturates at the overload maximum.
// - Start at overload maximum off-time, step down to the minimum.
// - Over-temperature inhibits all switch pulses.
// - Switching resumes only when over-temperature indication clears.
// - A cycle starts only while feedback input is below reference.
// - On-pulse ends at peak current or maximum on-time, first wins.
//
// Design decisions made here: register access over Wishbone and the register offsets.
module spoc_ctrl #(
  parameter int unsigned CNT_W        = 20,
  parameter int unsigned STEPS        = spoc_pkg::OFF_STEPS,
  parameter int unsigned OFF_MIN      = spoc_pkg::OFF_MIN_CYC,
  parameter int unsigned OFF_STEP     = spoc_pkg::OFF_STEP_CYC,
  parameter int unsigned ON_MAX       = spoc_pkg::ON_MAX_CYC,
  parameter int unsigned ON_TO        = spoc_pkg::ON_TO_CYC,
  parameter int unsigned BLANK        = spoc_pkg::BLANK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Analog front end
  input  wire logic        cur_over_i,
  input  wire logic        fb_below_ref_i,
  input  wire logic        over_temp_i,
  // Switch drive
  output logic             gate_o,
  output logic             gate_reset_n_o,
  output logic             cur_limit_o,
  output logic             irq_o,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam int unsigned IDX_W = $clog2(STEPS + 1);
  localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(STEPS);
  localparam logic [IDX_W-1:0] IDX_MIN = '0;
  localparam logic [CNT_W-1:0] BLANK_C = CNT_W'(BLANK);
  localparam logic [CNT_W-1:0] ON_MAX_C = CNT_W'(ON_MAX);
  localparam logic [CNT_W-1:0] ON_TO_C = CNT_W'(ON_TO);

  spoc_pkg::spoc_state_t state_q;
  logic [CNT_W-1:0]      on_cnt_q;
  logic [CNT_W-1:0]      off_cnt_q;
  logic [CNT_W-1:0]      off_len;
  logic [IDX_W-1:0]      idx_q;
  logic                  gate_q;
  logic                  gate_reset_n_q;
  logic                  cl_q;
  logic                  ot_q;
  logic                  en_q;
  logic [spoc_pkg::EV_W-1:0] status_q;
  logic [spoc_pkg::EV_W-1:0] mask_q;
  logic [spoc_pkg::EV_W-1:0] ev;
  logic                  irq_q;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic                  blanked;
  logic                  trip;
  logic                  on_end;
  logic                  short_on;
  logic                  long_on;
  logic                  wr_acc;

  // Off interval length for a given step index
  function automatic logic [CNT_W-1:0] off_cycles(
    input logic [IDX_W-1:0] idx);
    off_cycles = CNT_W'(OFF_MIN) + CNT_W'(idx) * CNT_W'(OFF_STEP);
  endfunction

  // Register hit decode, used by the write paths; the read path decodes in a case
  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] off);
    hit = (adr == off);
  endfunction

  // Pulse conditions
  assign blanked  = on_cnt_q < BLANK_C;
  assign trip     = cur_over_i && !blanked;
  assign on_end   = trip || (on_cnt_q >= ON_MAX_C - 1'b1) || ot_q;
  assign short_on = on_cnt_q + 1'b1 < ON_TO_C;
  assign long_on  = on_cnt_q + 1'b1 > ON_TO_C;
  assign off_len  = off_cycles(idx_q);
  // Writes land on the edge where the master sees ack, not before it
  assign wr_acc   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  // Thermal indication; sensor hysteresis decides when it clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ot_q <= 1'b0;
    end else begin
      ot_q <= over_temp_i;
    end
  end

  // Switching sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= spoc_pkg::SPOC_IDLE;
      on_cnt_q  <= '0;
      off_cnt_q <= '0;
      gate_q    <= 1'b0;
    end else begin
      unique case (state_q)
        spoc_pkg::SPOC_IDLE: begin
          on_cnt_q <= '0;
          // Only start with feedback low, enabled and cool
          if (en_q && fb_below_ref_i && !ot_q) begin
            gate_q  <= 1'b1;
            state_q <= spoc_pkg::SPOC_ON;
          end
        end
        spoc_pkg::SPOC_ON: begin
          if (on_end) begin
            gate_q    <= 1'b0;
            off_cnt_q <= '0;
            state_q   <= spoc_pkg::SPOC_OFF;
          end else begin
            on_cnt_q <= on_cnt_q + 1'b1;
          end
        end
        spoc_pkg::SPOC_OFF: begin
          // Off interval uses the index set at turn-off
          if (off_cnt_q >= off_len - 1'b1) begin
            state_q <= spoc_pkg::SPOC_IDLE;
          end else begin
            off_cnt_q <= off_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Current-limit flag and gate reset; cleared once gate has fallen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cl_q   <= 1'b0;
      gate_reset_n_q <= 1'b1;
    end else if (state_q == spoc_pkg::SPOC_ON && trip) begin
      cl_q   <= 1'b1;
      gate_reset_n_q <= 1'b0;
    end else if (state_q == spoc_pkg::SPOC_OFF && !gate_q) begin
      cl_q   <= 1'b0;
      gate_reset_n_q <= 1'b1;
    end
  end

  // Off-time step index; reset loads the overload maximum (soft start)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= IDX_MAX;
    end else if (state_q == spoc_pkg::SPOC_ON && on_end) begin
      if (short_on && idx_q != IDX_MAX) begin
        idx_q <= idx_q + 1'b1;
      end else if (long_on && idx_q != IDX_MIN) begin
        idx_q <= idx_q - 1'b1;
      end
    end
  end

  // Events raised by the controller
  always_comb begin
    ev = '0;
    ev[spoc_pkg::EV_CLIM]  = state_q == spoc_pkg::SPOC_ON && trip;
    ev[spoc_pkg::EV_UP]    = state_q == spoc_pkg::SPOC_ON && on_end &&
                             short_on;
    ev[spoc_pkg::EV_THERM] = over_temp_i && !ot_q;
    ev[spoc_pkg::EV_OVL]   = state_q == spoc_pkg::SPOC_ON && on_end &&
                             short_on && idx_q == IDX_MAX;
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (wr_acc && hit(wb_adr_i, spoc_pkg::REG_STATUS) &&
                 wb_sel_i[0]) begin
      status_q <= (status_q & ~wb_dat_i[spoc_pkg::EV_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= spoc_pkg::CTRL_RST;
      mask_q <= spoc_pkg::MASK_RST;
    end else if (wr_acc && wb_sel_i[0]) begin
      if (hit(wb_adr_i, spoc_pkg::REG_CTRL)) begin
        en_q <= wb_dat_i[spoc_pkg::CTRL_EN_BIT];
      end
      if (hit(wb_adr_i, spoc_pkg::REG_MASK)) begin
        mask_q <= wb_dat_i[spoc_pkg::EV_W-1:0];
      end
    end
  end

  // Interrupt level, registered so the pin comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Bus answer one edge after the request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
        unique case (wb_adr_i)
          spoc_pkg::REG_CTRL:
            dat_q[spoc_pkg::CTRL_EN_BIT] <= en_q;
          spoc_pkg::REG_STATUS:
            dat_q[spoc_pkg::EV_W-1:0] <= status_q;
          spoc_pkg::REG_MASK:
            dat_q[spoc_pkg::EV_W-1:0] <= mask_q;
          spoc_pkg::REG_STATE: begin
            dat_q[spoc_pkg::ST_GATE_BIT] <= gate_q;
            dat_q[spoc_pkg::ST_OT_BIT]   <= ot_q;
            dat_q[spoc_pkg::ST_CL_BIT]   <= cl_q;
            dat_q[spoc_pkg::ST_IDX_LSB +: IDX_W] <= idx_q;
          end
          default: dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign gate_o         = gate_q;
  assign gate_reset_n_o = gate_reset_n_q;
  assign cur_limit_o    = cl_q;
  assign irq_o          = irq_q;
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;

  // Checks
  sequence s_trip_on;
    state_q == spoc_pkg::SPOC_ON && trip;
  endsequence

  sequence s_gate_rise;
    $rose(gate_q);
  endsequence

  chk_trip_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_trip_on |=> !gate_q && cl_q && !gate_reset_n_q)
    else $error("trip did not drop gate and reset");

  chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(cl_q) |-> !gate_q && !$past(gate_q))
    else $error("limit flag cleared before gate fell");

  chk_blank_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_gate_rise |-> !cl_q [*2])
    else $error("limit flag rose inside blanking");

  chk_step_up: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == spoc_pkg::SPOC_ON && on_end && short_on && idx_q < IDX_MAX
    |=> idx_q == $past(idx_q) + 1'b1)
    else $error("short on-time did not lengthen off-time");

  chk_step_down: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == spoc_pkg::SPOC_ON && on_end && long_on && idx_q > IDX_MIN
    |=> idx_q == $past(idx_q) - 1'b1)
    else $error("long on-time did not shorten off-time");

  chk_step_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == spoc_pkg::SPOC_ON && on_end && short_on && idx_q == IDX_MAX
    |=> idx_q == IDX_MAX)
    else $error("off-time left overload maximum on short on-time");

  chk_only_turnoff: assert property (@(posedge clk_i) disable iff (rst_i)
    !(state_q == spoc_pkg::SPOC_ON && on_end) |=> $stable(idx_q))
    else $error("off-time changed outside turn-off");

  chk_hot_no_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ot_q && state_q != spoc_pkg::SPOC_ON |=> !$rose(gate_q))
    else $error("pulse started while hot");

  chk_fb_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_gate_rise |-> $past(fb_below_ref_i) && !$past(ot_q))
    else $error("pulse started with feedback high");

  chk_on_max: assert property (@(posedge clk_i) disable iff (rst_i)
    gate_q |-> on_cnt_q < ON_MAX_C)
    else $error("on-time exceeded its maximum");

  chk_off_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(gate_q) |-> !gate_q [*8])
    else $error("off interval too short");
endmodule

//--- bench/spoc_front_model.sv
// Behavioural analog front end: current sensor, feedback and temperature
module spoc_front_model (
  input  wire logic clk_i,
  input  wire logic gate_i,
  input  wire logic fb_req_i,
  input  wire logic ot_req_i,
  input  int        trip_after_i,
  output logic      cur_over_o     = 1'b0,
  output logic      fb_below_ref_o = 1'b0,
  output logic      over_temp_o    = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt = 0;
  // Current ramps only while the gate is on; zero trip count never trips
  always @(posedge clk_i) begin
    on_cnt         <= gate_i ? on_cnt + 1 : 0;
    cur_over_o     <= gate_i && trip_after_i != 0 &&
                      on_cnt + 1 >= trip_after_i;
    fb_below_ref_o <= fb_req_i;
    over_temp_o    <= ot_req_i;
  end
endmodule

//--- bench/spoc_ctrl_tb.sv
// Self-checking bench for the protection and off-time controller
module spoc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short sim counts; interval expectations derive from these, step indices use literal 15
  localparam int OFF_MIN  = 20;
  localparam int OFF_STEP = 10;
  localparam int ON_MAX   = 40;
  localparam int ON_TO    = 15;
  localparam int BLANK    = 4;
  logic        clk_i, rst_i, cur_over_i, fb_below_ref_i, over_temp_i;
  logic        gate_o, gate_reset_n_o, cur_limit_o, irq_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fb_req, ot_req;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          trip_after, fail_count, comparisons, on_len, gap, fall_c;
  int          cyc_n = 0;

  spoc_ctrl #(.CNT_W(20), .STEPS(15), .OFF_MIN(OFF_MIN),
    .OFF_STEP(OFF_STEP), .ON_MAX(ON_MAX), .ON_TO(ON_TO), .BLANK(BLANK)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cur_over_i(cur_over_i),
    .fb_below_ref_i(fb_below_ref_i), .over_temp_i(over_temp_i),
    .gate_o(gate_o), .gate_reset_n_o(gate_reset_n_o),
    .cur_limit_o(cur_limit_o), .irq_o(irq_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  spoc_front_model front (.clk_i(clk_i), .gate_i(gate_o),
    .fb_req_i(fb_req), .ot_req_i(ot_req), .trip_after_i(trip_after),
    .cur_over_o(cur_over_i), .fb_below_ref_o(fb_below_ref_i),
    .over_temp_o(over_temp_i));

  // 200 MHz clock and a free cycle count for interval timing
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    conclude();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_in(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Classic single cycle; ack is read as it stood before the edge
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) timeout();
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // One switching pulse: gap since last fall, on length, trip flags
  task automatic pulse(input logic trip);
    int n;
    n = 0;
    while (gate_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 3000) timeout();
    end
    gap = cyc_n - fall_c;
    on_len = 0;
    while (gate_o === 1'b1) begin
      check(cur_limit_o, 0);
      @(posedge clk_i);
      on_len++;
      if (on_len > 1000) timeout();
    end
    fall_c = cyc_n;
    check({cur_limit_o, gate_reset_n_o}, {trip, !trip});
    @(posedge clk_i);
    check({cur_limit_o, gate_reset_n_o}, 2'b01);
  endtask

  task automatic reset_values();
    check({gate_o, gate_reset_n_o, cur_limit_o, irq_o}, 4'h4);
    wb(1'b1, 4'hc, 32'h0000_ffff);
    wb(1'b0, 4'hc, 32'h0000_0000);
    check(rd, 32'h0000_0f00);
    wb(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wb(1'b0, 4'h1, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wb(1'b0, 4'h0, 32'h0000_0000);
    check({rd[30:0], gate_o}, 32'h0000_0000);
  endtask

  // No trip: every pulse runs to the maximum and the off-time walks down
  task automatic soft_start();
    int e;
    wb(1'b1, 4'h0, 32'h0000_0001);
    pulse(1'b0);
    for (int k = 1; k <= 16; k++) begin
      e = (k > 15) ? 0 : 15 - k;
      check_in(on_len, ON_MAX - 1, ON_MAX + 1);
      wb(1'b0, 4'hc, 32'h0000_0000);
      check(rd[11:8], e);
      pulse(1'b0);
      check_in(gap, OFF_MIN + e * OFF_STEP, OFF_MIN + e * OFF_STEP + 3);
    end
  endtask

  // Immediate trip: short on-times walk the off-time up to its ceiling
  task automatic runaway();
    int e;
    trip_after <= 1;
    for (int k = 1; k <= 16; k++) begin
      pulse(1'b1);
      check_in(on_len, BLANK, ON_TO - 1);
      e = (k > 15) ? 15 : k;
      wb(1'b0, 4'hc, 32'h0000_0000);
      check(rd[11:8], e);
    end
    wb(1'b0, 4'h4, 32'h0000_0000);
    check({rd[3:0], irq_o}, 5'h16);
  endtask

  task automatic thermal();
    wb(1'b1, 4'h8, 32'h0000_0004);
    ot_req <= 1'b1;
    repeat (8) @(posedge clk_i);
    repeat (300) begin
      @(posedge clk_i);
      check(gate_o, 0);
    end
    check(irq_o, 1);
    wb(1'b0, 4'hc, 32'h0000_0000);
    check(rd, 32'h0000_0f02);
    wb(1'b1, 4'h4, 32'h0000_000f);
    repeat (2) @(posedge clk_i);
    wb(1'b0, 4'h4, 32'h0000_0000);
    check({rd[3:0], irq_o, gate_o}, 6'h0);
    ot_req <= 1'b0;
    pulse(1'b1);
  endtask

  // Feedback above reference holds off any new cycle
  task automatic feedback();
    fb_req <= 1'b0;
    repeat (400) begin
      @(posedge clk_i);
      check(gate_o, 0);
    end
    fb_req <= 1'b1;
    pulse(1'b1);
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    fb_req = 1'b1;
    ot_req = 1'b0;
    trip_after = 0;
    fail_count = 0;
    comparisons = 0;
    fall_c = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    reset_values();
    soft_start();
    runaway();
    thermal();
    feedback();
    conclude();
  end
endmodule
